// ===== rtl/cpr_pkg.sv
// Constants for the codec path control register bank.
// Assumes a host that reaches the bank through the serial control port.
package cpr_pkg;

  // ----------------------------------------------------------------------
  // Register addresses (address byte bits 6..3)
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_PCM   = 4'h1;
  localparam logic [3:0] ADDR_RXINJ = 4'h2;
  localparam logic [3:0] ADDR_TXINJ = 4'h3;
  localparam logic [3:0] ADDR_ROUTE = 4'h4;
  localparam logic [3:0] ADDR_GAIN  = 4'h5;
  localparam logic [3:0] ADDR_ATTEN = 4'h6;

  // ----------------------------------------------------------------------
  // Address byte fields
  // ----------------------------------------------------------------------
  localparam int BIT_SECOND = 1;
  localparam int BIT_READ   = 2;
  localparam int ADDR_LSB   = 3;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PCM_TIMING_HI = 7;
  localparam int PCM_TIMING_LO = 6;
  localparam int PCM_LATCH     = 5;
  localparam int PCM_RX_SRC    = 4;
  localparam int PCM_TX_SRC    = 3;
  localparam int PCM_VOICE_EN  = 2;
  localparam int PCM_SLOT      = 1;
  localparam int PCM_CLK_SRC   = 0;
  localparam int RT_MIC_HI     = 7;
  localparam int RT_MIC_LO     = 6;
  localparam int RT_SIDETONE   = 5;
  localparam int RT_OUT_HI     = 4;
  localparam int RT_OUT_LO     = 3;
  localparam int RT_TONE       = 2;
  localparam int RT_HP_BYPASS  = 1;
  localparam int RT_RX_ON      = 0;

  // ----------------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] OUT_FORBIDDEN = 2'h3;

  typedef enum logic [1:0] {
    TIMING_DELAYED  = 2'b00,
    TIMING_NORMAL   = 2'b01,
    TIMING_REVERSE  = 2'b10
  } cpr_timing_t;

  typedef enum logic [1:0] {
    ST_ADDR = 2'b00,
    ST_DATA = 2'b01
  } cpr_state_t;

endpackage

// ===== rtl/cpr_regs.sv
// Codec path control register bank with its serial control port.
// Assumes chip select, serial clock edge and data are already synchronous.
`timescale 1ns/1ps
module cpr_regs
(
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       clk_en_i,
  input  wire logic       ctl_sel_n_i,
  input  wire logic       ctl_shift_i,
  input  wire logic       ctl_data_i,
  input  wire logic       companded_i,
  input  wire logic [7:0] rx_path_byte_i,
  input  wire logic [7:0] serial_rx_in_byte_i,
  input  wire logic       rx_byte_stb_i,
  input  wire logic [7:0] tx_path_byte_i,
  output logic            ctl_data_o,
  output logic [1:0]      timing_mode_o,
  output logic            general_latch_out_o,
  output logic [7:0]      rx_path_feed_o,
  output logic [7:0]      serial_tx_out_byte_o,
  output logic            voice_xfer_on_o,
  output logic            slot_channel_sel_o,
  output logic            clock_source_sel_o,
  output logic [1:0]      mic_sel_o,
  output logic            sidetone_on_o,
  output logic            earpiece_out_on_o,
  output logic            loudspeaker_out_on_o,
  output logic            tone_to_output_on_o,
  output logic            highpass_on_o,
  output logic            rx_signal_on_o,
  output logic [3:0]      tx_gain_code_o,
  output logic [3:0]      sidetone_gain_code_o,
  output logic [3:0]      earpiece_atten_o,
  output logic [3:0]      extra_amp_atten_o
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0]          pcm_reg;
  logic [7:0]          rxinj_reg;
  logic [7:0]          rxcap_reg;
  logic [7:0]          txinj_reg;
  logic [7:0]          route_reg;
  logic [7:0]          gain_reg;
  logic [7:0]          atten_reg;
  logic [7:0]          shift_reg;
  logic [7:0]          addr_reg;
  logic [7:0]          rd_reg;
  logic [2:0]          cnt_reg;
  cpr_pkg::cpr_state_t state_reg;

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  wire        active    = clk_en_i && !ctl_sel_n_i && ctl_shift_i;
  wire [7:0]  shifted   = {shift_reg[6:0], ctl_data_i};
  wire        byte_done = active && (cnt_reg == 3'h7);
  wire        in_data   = (state_reg == cpr_pkg::ST_DATA);
  wire [3:0]  sel       = addr_reg[cpr_pkg::ADDR_LSB +: 4];
  wire        wr_now    = byte_done && in_data && !addr_reg[cpr_pkg::BIT_READ];
  wire        has_data  = shifted[cpr_pkg::BIT_SECOND];
  wire        rd_req    = shifted[cpr_pkg::BIT_READ];
  wire [3:0]  rd_sel    = shifted[cpr_pkg::ADDR_LSB +: 4];
  wire        route_ok  = shifted[cpr_pkg::RT_OUT_HI -: 2]
                          != cpr_pkg::OUT_FORBIDDEN;

  // Reading the receive-injection address returns received data.
  function automatic logic [7:0] read_mux
  (
    input logic [3:0] a
  );
    logic [7:0] v;
    v = 8'h00;
    if (a == cpr_pkg::ADDR_PCM)
      v = pcm_reg;
    else if (a == cpr_pkg::ADDR_RXINJ)
      v = rxcap_reg;
    else if (a == cpr_pkg::ADDR_ROUTE)
      v = route_reg;
    else if (a == cpr_pkg::ADDR_GAIN)
      v = gain_reg;
    else if (a == cpr_pkg::ADDR_ATTEN)
      v = atten_reg;
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // Serial control port (address byte then data byte, MSB first)
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      shift_reg <= 8'h00;
      addr_reg  <= 8'h00;
      rd_reg    <= 8'h00;
      cnt_reg   <= 3'h0;
      state_reg <= cpr_pkg::ST_ADDR;
    end
    else if (clk_en_i && ctl_sel_n_i)
    begin
      cnt_reg   <= 3'h0;
      state_reg <= cpr_pkg::ST_ADDR;
    end
    else if (active)
    begin
      shift_reg <= shifted;
      cnt_reg   <= cnt_reg + 3'h1;
      rd_reg    <= {rd_reg[6:0], 1'b0};
      if (byte_done && !in_data && has_data)
      begin
        addr_reg  <= shifted;
        state_reg <= cpr_pkg::ST_DATA;
        if (rd_req)
          rd_reg <= read_mux(rd_sel);
      end
      else if (byte_done)
        state_reg <= cpr_pkg::ST_ADDR;
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      pcm_reg   <= cpr_pkg::RESET_BYTE;
      rxinj_reg <= cpr_pkg::RESET_BYTE;
      rxcap_reg <= cpr_pkg::RESET_BYTE;
      txinj_reg <= cpr_pkg::RESET_BYTE;
      route_reg <= cpr_pkg::RESET_BYTE;
      gain_reg  <= cpr_pkg::RESET_BYTE;
      atten_reg <= cpr_pkg::RESET_BYTE;
    end
    else if (clk_en_i)
    begin
      if (rx_byte_stb_i)
        rxcap_reg <= serial_rx_in_byte_i;
      if (wr_now && sel == cpr_pkg::ADDR_PCM)
        pcm_reg <= shifted;
      if (wr_now && sel == cpr_pkg::ADDR_RXINJ)
        rxinj_reg <= shifted;
      if (wr_now && sel == cpr_pkg::ADDR_TXINJ)
        txinj_reg <= shifted;
      // A forbidden output code is dropped so both outputs never drive.
      if (wr_now && sel == cpr_pkg::ADDR_ROUTE && route_ok)
        route_reg <= shifted;
      if (wr_now && sel == cpr_pkg::ADDR_GAIN)
        gain_reg <= shifted;
      if (wr_now && sel == cpr_pkg::ADDR_ATTEN)
        atten_reg <= shifted;
    end
  end

  // ----------------------------------------------------------------------
  // Path control decode
  // ----------------------------------------------------------------------
  wire [1:0] tsel = pcm_reg[cpr_pkg::PCM_TIMING_HI -: 2];
  wire [1:0] timing_w = !tsel[1] ? cpr_pkg::TIMING_DELAYED :
                        (tsel[0] ? cpr_pkg::TIMING_REVERSE
                                 : cpr_pkg::TIMING_NORMAL);
  wire       cmp    = companded_i;
  wire       rx_inj = pcm_reg[cpr_pkg::PCM_RX_SRC] && cmp;
  wire       tx_inj = pcm_reg[cpr_pkg::PCM_TX_SRC] && cmp;
  wire [7:0] rx_w   = rx_inj ? rxinj_reg : rx_path_byte_i;
  wire [7:0] tx_w   = tx_inj ? txinj_reg : tx_path_byte_i;
  wire [1:0] osel   = route_reg[cpr_pkg::RT_OUT_HI -: 2];
  wire       rx_en  = route_reg[cpr_pkg::RT_RX_ON];

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      ctl_data_o           <= 1'b0;
      timing_mode_o        <= cpr_pkg::TIMING_DELAYED;
      general_latch_out_o  <= 1'b1;
      rx_path_feed_o       <= 8'h00;
      serial_tx_out_byte_o <= 8'h00;
      voice_xfer_on_o      <= 1'b0;
      slot_channel_sel_o   <= 1'b0;
      clock_source_sel_o   <= 1'b0;
      mic_sel_o            <= 2'h0;
      sidetone_on_o        <= 1'b0;
      earpiece_out_on_o    <= 1'b0;
      loudspeaker_out_on_o <= 1'b0;
      tone_to_output_on_o  <= 1'b0;
      highpass_on_o        <= 1'b1;
      rx_signal_on_o       <= 1'b0;
      tx_gain_code_o       <= 4'h0;
      sidetone_gain_code_o <= 4'h0;
      earpiece_atten_o     <= 4'h0;
      extra_amp_atten_o    <= 4'h0;
    end
    else if (clk_en_i)
    begin
      ctl_data_o           <= rd_reg[7];
      timing_mode_o        <= timing_w;
      general_latch_out_o  <= !pcm_reg[cpr_pkg::PCM_LATCH];
      rx_path_feed_o       <= rx_w;
      serial_tx_out_byte_o <= tx_w;
      voice_xfer_on_o      <= pcm_reg[cpr_pkg::PCM_VOICE_EN];
      slot_channel_sel_o   <= pcm_reg[cpr_pkg::PCM_SLOT] && cmp;
      clock_source_sel_o   <= pcm_reg[cpr_pkg::PCM_CLK_SRC];
      mic_sel_o            <= route_reg[cpr_pkg::RT_MIC_HI -: 2];
      sidetone_on_o        <= route_reg[cpr_pkg::RT_SIDETONE];
      earpiece_out_on_o    <= (osel == 2'h1);
      loudspeaker_out_on_o <= (osel == 2'h2);
      tone_to_output_on_o  <= route_reg[cpr_pkg::RT_TONE];
      highpass_on_o        <= !route_reg[cpr_pkg::RT_HP_BYPASS];
      rx_signal_on_o       <= rx_en;
      tx_gain_code_o       <= gain_reg[7:4];
      sidetone_gain_code_o <= gain_reg[3:0];
      earpiece_atten_o     <= atten_reg[7:4];
      extra_amp_atten_o    <= atten_reg[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_TIMING: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i && !pcm_reg[7] |=> timing_mode_o == cpr_pkg::TIMING_DELAYED)
    else $error("Timing mode not delayed with top bit clear.");

  AST_RX_SRC: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i && rx_inj |=> rx_path_feed_o == $past(rxinj_reg))
    else $error("Receive path not fed from injection register.");

  AST_RX_PATH: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i && !rx_inj |=> rx_path_feed_o == $past(rx_path_byte_i))
    else $error("Receive path not fed from serial input.");

  AST_TX_SRC: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i && !pcm_reg[3] |=> serial_tx_out_byte_o == $past(tx_path_byte_i))
    else $error("Transmit output not from transmit path.");

  AST_TX_INJ: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i && tx_inj |=> serial_tx_out_byte_o == $past(txinj_reg))
    else $error("Transmit output not from injection register.");

  AST_VOICE: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i |=> voice_xfer_on_o == $past(pcm_reg[2]))
    else $error("Voice enable does not follow its bit.");

  AST_SLOT: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i |=> slot_channel_sel_o == $past(pcm_reg[1] && companded_i))
    else $error("Slot channel select wrong.");

  AST_CLK_SRC: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i |=> clock_source_sel_o == $past(pcm_reg[0]))
    else $error("Clock source select does not follow its bit.");

  AST_RXCAP: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i && rx_byte_stb_i |=> rxcap_reg == $past(serial_rx_in_byte_i))
    else $error("Received byte not captured for readback.");

  AST_MIC: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i |=> mic_sel_o == $past(route_reg[7:6]))
    else $error("Microphone select does not follow its field.");

  AST_SIDETONE: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i |=> sidetone_on_o == $past(route_reg[5]))
    else $error("Sidetone enable does not follow its bit.");

  AST_OUT_EXCL: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    !(earpiece_out_on_o && loudspeaker_out_on_o))
    else $error("Earpiece and loudspeaker both selected.");

  AST_ROUTE_KEEP: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    wr_now && sel == cpr_pkg::ADDR_ROUTE && !route_ok
    |=> route_reg == $past(route_reg))
    else $error("Forbidden output code was stored.");

  AST_EAR_SEL: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i |=> earpiece_out_on_o == ($past(route_reg[4:3]) == 2'h1))
    else $error("Earpiece select does not follow its code.");

  AST_TONE: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i |=> tone_to_output_on_o == $past(route_reg[2]))
    else $error("Tone routing does not follow its bit.");

  AST_HPF: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i |=> highpass_on_o != $past(route_reg[1]))
    else $error("High-pass polarity wrong.");

  AST_RX_ON: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i |=> rx_signal_on_o == $past(route_reg[0]))
    else $error("Receive signal enable does not follow its bit.");

  AST_SIDE_GAIN: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i |=> sidetone_gain_code_o == $past(gain_reg[3:0]))
    else $error("Sidetone gain code does not follow its nibble.");

  AST_ATTEN: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i |=> {earpiece_atten_o, extra_amp_atten_o} == $past(atten_reg))
    else $error("Attenuation codes do not follow their nibbles.");

  AST_GAIN_WR: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    wr_now && sel == cpr_pkg::ADDR_GAIN ##1 clk_en_i [*2]
    |-> tx_gain_code_o == $past(shifted[7:4], 2))
    else $error("Transmit gain code not updated after write.");
  AST_RESET: assert property (@(posedge sys_clk_i)
    $past(!reset_n_i) |-> route_reg == 8'h00 && gain_reg == 8'h00)
    else $error("Registers not cleared by reset.");

endmodule // cpr_regs

// ===== verification/cpr_host_model.sv
// Host controller model driving the serial control port of the bank.
// Assumes the caller enters frame just after a rising clock edge.
`timescale 1ns/1ps
module cpr_host_model
(
  input  wire logic sys_clk_i,
  input  wire logic rdata_i,
  output logic      sel_n_o,
  output logic      shift_o,
  output logic      sdata_o
);
  int gap = 2;

  initial
  begin
    sel_n_o = 1'b1;
    shift_o = 1'b0;
    sdata_o = 1'b0;
  end

  // Fewer than sixteen bits models a frame aborted by deselection.
  task automatic frame(input logic [15:0] word, input int nbits,
                       output logic [7:0] q);
    q = 8'h00;
    sel_n_o = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      if (i >= 8)
        q[15 - i] = rdata_i;
      sdata_o = word[15 - i];
      shift_o = 1'b1;
      @(posedge sys_clk_i) #1;
      shift_o = 1'b0;
      repeat (gap) @(posedge sys_clk_i) #1;
    end
    // A released line shows the inverse so a stale level cannot pass.
    sel_n_o = 1'b1;
    sdata_o = ~sdata_o;
    repeat (2) @(posedge sys_clk_i) #1;
  endtask
endmodule // cpr_host_model

// ===== verification/test_codec_path_control_regs.sv
// Self-checking bench for the codec path control register bank.
// Assumes the host model is the only driver of the control port.
`timescale 1ns/1ps
module test_codec_path_control_regs;
  logic       sys_clk_i, reset_n_i, clk_en_i, companded_i, rx_byte_stb_i;
  logic [7:0] rx_path_byte_i, serial_rx_in_byte_i, tx_path_byte_i;
  logic       ctl_sel_n_i, ctl_shift_i, ctl_data_i, ctl_data_o;
  logic [1:0] timing_mode_o, mic_sel_o;
  logic [7:0] rx_path_feed_o, serial_tx_out_byte_o, q;
  logic [3:0] tx_gain_code_o, sidetone_gain_code_o;
  logic [3:0] earpiece_atten_o, extra_amp_atten_o;
  logic       general_latch_out_o, voice_xfer_on_o, slot_channel_sel_o;
  logic       clock_source_sel_o, sidetone_on_o, earpiece_out_on_o;
  logic       loudspeaker_out_on_o, tone_to_output_on_o, highpass_on_o;
  logic       rx_signal_on_o;
  int         errors, cmp_count, rxcap, a, d;
  int         regs [8];

  cpr_regs i_dut
  (
    .sys_clk_i, .reset_n_i, .clk_en_i, .ctl_sel_n_i, .ctl_shift_i,
    .ctl_data_i, .companded_i, .rx_path_byte_i, .serial_rx_in_byte_i,
    .rx_byte_stb_i, .tx_path_byte_i, .ctl_data_o, .timing_mode_o,
    .general_latch_out_o, .rx_path_feed_o, .serial_tx_out_byte_o,
    .voice_xfer_on_o, .slot_channel_sel_o, .clock_source_sel_o, .mic_sel_o,
    .sidetone_on_o, .earpiece_out_on_o, .loudspeaker_out_on_o,
    .tone_to_output_on_o, .highpass_on_o, .rx_signal_on_o, .tx_gain_code_o,
    .sidetone_gain_code_o, .earpiece_atten_o, .extra_amp_atten_o
  );
  cpr_host_model i_host
  (
    .sys_clk_i, .rdata_i (ctl_data_o), .sel_n_o (ctl_sel_n_i),
    .shift_o (ctl_shift_i), .sdata_o (ctl_data_i)
  );

  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------------------------------------
  // Comparison, model and host access
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: %s seen %0h expected %0h", $time, what,
               seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check_all();
    int         p;
    int         r;
    logic [1:0] tm;
    p = regs[1];
    r = regs[4];
    tm = p[7] ? (p[6] ? 2'h2 : 2'h1) : 2'h0;
    repeat (3) @(posedge sys_clk_i) #1;
    check({timing_mode_o, general_latch_out_o}, {tm, ~p[5]}, "timing");
    check({voice_xfer_on_o, slot_channel_sel_o, clock_source_sel_o},
          {p[2], p[1] & companded_i, p[0]}, "pcm bits");
    check(rx_path_feed_o, (p[4] && companded_i) ? regs[2] : rx_path_byte_i,
          "rx feed");
    check(serial_tx_out_byte_o, (p[3] && companded_i) ? regs[3] :
          tx_path_byte_i, "tx out");
    check({mic_sel_o, sidetone_on_o}, {r[7:6], r[5]}, "mic");
    check({earpiece_out_on_o, loudspeaker_out_on_o},
          {r[4:3] == 2'h1, r[4:3] == 2'h2}, "out sel");
    check({tone_to_output_on_o, highpass_on_o, rx_signal_on_o},
          {r[2], ~r[1], r[0]}, "route");
    check({tx_gain_code_o, sidetone_gain_code_o}, regs[5], "gain");
    check({earpiece_atten_o, extra_amp_atten_o}, regs[6], "atten");
  endtask

  task automatic host_io(input int ad, input int rd, input int dt, input int n);
    i_host.frame({1'b0, ad[3:0], rd[0], 1'b1, 1'b0, dt[7:0]}, n, q);
  endtask

  task automatic wr(input int ad, input int dt);
    host_io(ad, 0, dt, 16);
    // An output field of 11 is refused and the whole write dropped.
    if (ad >= 1 && ad <= 6 && !(ad == 4 && dt[4:3] == 2'h3))
      regs[ad] = dt;
    check_all();
  endtask

  task automatic rd_chk(input int ad);
    host_io(ad, 1, 0, 16);
    check(q, (ad == 2) ? rxcap : ((ad >= 1 && ad <= 6) ? regs[ad] : 0),
          "readback");
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial
  begin
    {errors, cmp_count, rxcap} = '0;
    foreach (regs[k]) regs[k] = 0;
    {reset_n_i, companded_i, rx_byte_stb_i} = 3'h0;
    clk_en_i = 1'b1;
    {rx_path_byte_i, tx_path_byte_i, serial_rx_in_byte_i} = 24'h000000;
    void'($urandom(75));
    repeat (16) @(posedge sys_clk_i) #1;
    reset_n_i = 1'b1;
    check_all();
    for (int t = 1; t <= 6; t++) if (t != 3) rd_chk(t);
    for (int t = 0; t < 4; t++)
    begin
      wr(1, t << 6);
      wr(4, t << 3);
    end
    for (int n = 0; n < 48; n++)
    begin
      i_host.gap = (n < 24) ? 2 : 5;
      companded_i = 1'($urandom);
      {rx_path_byte_i, tx_path_byte_i, serial_rx_in_byte_i} = 24'($urandom);
      a = $urandom_range(6, 1);
      d = $urandom_range(255, 0);
      wr(a, d);
      if (a != 3) rd_chk(a);
    end
    serial_rx_in_byte_i = 8'($urandom);
    rx_byte_stb_i = 1'b1;
    @(posedge sys_clk_i) #1;
    rx_byte_stb_i = 1'b0;
    rxcap = serial_rx_in_byte_i;
    rd_chk(2);
    wr(7, 8'hA5);
    rd_chk(7);
    host_io(5, 0, 8'h3C, 12);
    check_all();
    clk_en_i = 1'b0;
    host_io(6, 0, 8'h5A, 16);
    clk_en_i = 1'b1;
    check_all();
    reset_n_i = 1'b0;
    repeat (16) @(posedge sys_clk_i) #1;
    reset_n_i = 1'b1;
    foreach (regs[k]) regs[k] = 0;
    check_all();
    wrap_up();
  end

  initial
  begin
    repeat (90000) @(posedge sys_clk_i);
    errors++;
    $display("ERROR at %0t: run did not finish", $time);
    wrap_up();
  end
endmodule // test_codec_path_control_regs
